/* File: verilog/sfid_regs.vh */
`ifndef SFID_REGS_VH
`define SFID_REGS_VH
// Purpose: constants for the serial flash instruction host controller
// Assumes: 25 MHz core clock, serial clock derived by divider
// Notes: opcodes of the flash instruction set
`define SFID_OP_WREN      8'h06
`define SFID_OP_WRDI      8'h04
`define SFID_OP_RDSR      8'h05
`define SFID_OP_WRSR      8'h01
`define SFID_OP_READ      8'h03
`define SFID_OP_FREAD     8'h0B
`define SFID_OP_PROG      8'h02
`define SFID_OP_SERASE    8'hD8
`define SFID_OP_CERASE    8'hC7
`define SFID_OP_PDOWN     8'hB9
`define SFID_OP_PPREAD    8'h53
`define SFID_OP_PPFREAD   8'h5B
`define SFID_OP_PPPROG    8'h52
`define SFID_OP_PPERASE   8'hD5
`define SFID_OP_RELPD     8'hAB
`define SFID_OP_MFID      8'h90
`define SFID_OP_JEDID     8'h9F
`define SFID_ID_PAD       8'h00
`define SFID_DIV_HALF     4'h3
`define SFID_DIV_ZERO     4'h0
`define SFID_BIT_LAST     3'h7
`define SFID_BIT_ZERO     3'h0
`define SFID_BYTE_ZERO    9'h000
`define SFID_BYTE_ONE     9'h001
`define SFID_PROG_MAX     9'h100
`define SFID_ADDR_LSB     0
`define SFID_TICK_HALF    1'b1
`endif

/* File: verilog/sfid_clkdiv.v */
// Purpose: one-cycle enable pulse every half serial clock period
// Assumes: single core clock domain
// Notes: run low stops the count so every frame starts in phase
`include "sfid_regs.vh"
module sfid_clkdiv (
	// clock and reset
	input  wire       core_clk,
	input  wire       arst_n,
	// control
	input  wire       run,
	output reg        tick
);
	reg [3:0] count;

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			count <= 4'h0;
			tick  <= 1'b0;
		end else if (!run) begin
			count <= `SFID_DIV_ZERO;
			tick  <= 1'b0;
		end else if (count == `SFID_DIV_HALF) begin
			count <= `SFID_DIV_ZERO;
			tick  <= 1'b1;
		end else begin
			count <= count + 4'h1;
			tick  <= 1'b0;
		end
	end
endmodule // sfid_clkdiv

/* File: verilog/sfid_host.v */
// Purpose: host controller that frames flash instructions on the serial pins
// Assumes: the flash answers on serial_out, host makes the serial clock (mode 0)
// Notes:
// Notes on behaviour
// R1: chip select falls, then the opcode byte is the first byte sent
// R2: host drives serial_in; flash samples at rising clock, MSB first
// R3: raising chip select completes the instruction
// R4: read instructions may end after any clocked bit
// R5: write, program and erase frames end only on a whole byte
// R6: while busy the flash ignores all but status read
// R7: 06h sets, 04h clears the write permission latch; single byte each
// R8: after 05h status bits repeat until chip select rises
// R9: 01h carries exactly one status data byte
// R10: 03h sends three address bytes high first, then reads stream
// R11: 0Bh adds one dummy byte before data
// R12: 02h sends address then up to 256 program bytes
// R13: program start address must be even
// R14: D8h takes an address; C7h and B9h are single bytes
// R15: 53h and 5Bh send two ignored bytes then an offset; 5Bh adds dummy
// R16: 52h sends two ignored bytes, offset, up to 256 bytes; D5h single byte
// R17: ABh leaves power-down; with three dummies returns part code byte
// R18: 90h sends two dummies and 00h, then reads two id bytes
// R19: 9Fh reads three identification bytes with no address
// R20: returned bytes arrive MSB first
// R21: flash changes serial_out on falling clock; host samples on rising
// R22: host issues write enable before program, erase, status write
// R23: flash advances the address after each read byte
// R24: undefined opcodes are ignored by the flash
// R25: serial_out is undriven while chip select high and during command phase; the flash model toggles it there instead
module sfid_host (
	// clock and reset
	input  wire        core_clk,
	input  wire        arst_n,
	// command port
	input  wire        cmd_valid,
	input  wire [7:0]  cmd_opcode,
	input  wire [23:0] cmd_addr,
	input  wire [8:0]  cmd_wr_count,
	input  wire [8:0]  cmd_rd_count,
	input  wire        cmd_auto_wren,
	output reg         cmd_ready,
	// write data stream
	input  wire [7:0]  wr_data,
	output reg         wr_take,
	// read data stream
	output reg  [7:0]  rd_data,
	output reg         rd_valid,
	output reg         done,
	output reg         cmd_error,
	// flash pins
	output reg         chip_select_n,
	output reg         serial_clk,
	output reg         serial_in,
	input  wire        serial_out
);
`include "sfid_regs.vh"

	localparam [4:0] ST_IDLE = 5'b00001;
	localparam [4:0] ST_SEL  = 5'b00010;
	localparam [4:0] ST_SHIFT = 5'b00100;
	localparam [4:0] ST_END  = 5'b01000;
	localparam [4:0] ST_GAP  = 5'b10000;

	reg  [4:0]  state;
	reg  [7:0]  opcode;
	reg  [23:0] addr;
	reg  [8:0]  wr_left;
	reg  [8:0]  rd_left;
	reg         wren_pending;
	reg  [2:0]  hdr_left;      // header bytes after the opcode
	reg  [2:0]  bit_idx;
	reg  [7:0]  tx_byte;
	reg  [7:0]  rx_byte;
	reg  [7:0]  next_tx;
	reg  [2:0]  next_hdr;
	reg         is_write;
	reg         so_meta;
	reg         so_sync;
	reg         rd_phase;      // header done, bytes now come back
	reg  [2:0]  hdr_pos;
	wire        fast_op;
	wire [7:0]  first_byte;
	wire        tick;

	assign fast_op    = (opcode == `SFID_OP_FREAD) || (opcode == `SFID_OP_PPFREAD);
	assign first_byte = wren_pending ? `SFID_OP_WREN : opcode;

	// serial_out crosses from the flash side, two flops before use
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			so_meta <= 1'b0;
			so_sync <= 1'b0;
		end else begin
			so_meta <= serial_out;
			so_sync <= so_meta;
		end
	end

	sfid_clkdiv u_div (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.run      (state == ST_SHIFT),
		.tick     (tick)
	);

	// header length per opcode; unknown opcodes go out alone
	always @* begin
		next_hdr = 3'h0;
		is_write = 1'b0;
		case (cmd_opcode)
			`SFID_OP_READ, `SFID_OP_PPREAD: next_hdr = 3'h3;               // R10 R15
			`SFID_OP_FREAD, `SFID_OP_PPFREAD: next_hdr = 3'h4;             // R11 R15
			`SFID_OP_RELPD, `SFID_OP_MFID: next_hdr = 3'h3;                // R17 R18
			`SFID_OP_PROG, `SFID_OP_PPPROG, `SFID_OP_SERASE: begin         // R12 R14 R16
				next_hdr = 3'h3;
				is_write = 1'b1;
			end
			`SFID_OP_WRSR, `SFID_OP_CERASE, `SFID_OP_PPERASE: is_write = 1'b1; // R9 R14 R16
			default: next_hdr = 3'h0;                                      // R7 R8 R19 R24
		endcase
	end

	// header byte after the opcode: address high first, fast forms end on a pad
	always @* begin
		next_tx = `SFID_ID_PAD;
		hdr_pos = hdr_left - {2'b00, fast_op};                               // R11
		if (opcode != `SFID_OP_MFID && opcode != `SFID_OP_RELPD) begin      // R17 R18
			case (hdr_pos)
				3'h3: next_tx = addr[23:16];                                // R10
				3'h2: next_tx = addr[15:8];                                 // R15 R16
				3'h1: next_tx = addr[7:0];
				default: next_tx = `SFID_ID_PAD;
			endcase
		end
	end

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state         <= ST_IDLE;
			opcode        <= 8'h00;
			addr          <= 24'h000000;
			wr_left       <= 9'h000;
			rd_left       <= 9'h000;
			wren_pending  <= 1'b0;
			hdr_left      <= 3'h0;
			bit_idx       <= 3'h0;
			tx_byte       <= 8'h00;
			rx_byte       <= 8'h00;
			rd_phase      <= 1'b0;
			cmd_ready     <= 1'b0;
			wr_take       <= 1'b0;
			rd_data       <= 8'h00;
			rd_valid      <= 1'b0;
			done          <= 1'b0;
			cmd_error     <= 1'b0;
			chip_select_n <= 1'b1;
			serial_clk    <= 1'b0;
			serial_in     <= 1'b0;
		end else begin
			wr_take   <= 1'b0;
			rd_valid  <= 1'b0;
			done      <= 1'b0;
			cmd_error <= 1'b0;
			case (state)
				ST_IDLE: begin
					cmd_ready <= 1'b1;
					if (cmd_valid && cmd_ready) begin
						cmd_ready <= 1'b0;
						// odd program address or oversize page is refused
						if ((cmd_opcode == `SFID_OP_PROG || cmd_opcode == `SFID_OP_PPPROG) &&
						    (cmd_addr[`SFID_ADDR_LSB] || cmd_wr_count > `SFID_PROG_MAX)) begin // R13 R12
							cmd_error <= 1'b1;
							done      <= 1'b1;
						end else begin
							opcode       <= cmd_opcode;
							addr         <= cmd_addr;
							hdr_left     <= next_hdr;
							wr_left      <= (cmd_opcode == `SFID_OP_WRSR) ? `SFID_BYTE_ONE :       // R9
							                (cmd_opcode == `SFID_OP_PROG || cmd_opcode == `SFID_OP_PPPROG) ?
							                cmd_wr_count : `SFID_BYTE_ZERO;
							rd_left      <= is_write ? `SFID_BYTE_ZERO : cmd_rd_count;
							wren_pending <= is_write && cmd_auto_wren;                              // R22
							state        <= ST_SEL;
						end
					end
				end
				ST_SEL: begin
					chip_select_n <= 1'b0;                                                 // R1
					bit_idx       <= `SFID_BIT_LAST;
					tx_byte       <= first_byte;                                           // R22
					serial_in     <= first_byte[7];                                        // R2
					rd_phase      <= 1'b0;
					serial_clk    <= 1'b0;
					state         <= ST_SHIFT;
				end
				ST_SHIFT: if (tick) begin
					serial_clk <= ~serial_clk;
					if (!serial_clk) begin
						// rising edge: flash samples serial_in, host samples serial_out
						rx_byte <= {rx_byte[6:0], so_sync};                              // R20 R21
					end else if (bit_idx != `SFID_BIT_ZERO) begin
						bit_idx   <= bit_idx - 3'h1;
						serial_in <= tx_byte[bit_idx - 3'h1];                             // R2
					end else begin
						// byte boundary reached on the falling edge
						bit_idx <= `SFID_BIT_LAST;
						if (wren_pending) begin
							state <= ST_END;                                              // R7
						end else if (hdr_left != 3'h0) begin
							hdr_left  <= hdr_left - 3'h1;
							tx_byte   <= next_tx;
							serial_in <= next_tx[7];
						end else if (wr_left != `SFID_BYTE_ZERO) begin
							wr_left   <= wr_left - 9'h001;
							wr_take   <= 1'b1;
							tx_byte   <= wr_data;
							serial_in <= wr_data[7];
						end else if (rd_phase) begin
							// rx_byte is whole after the eighth rising edge
							rd_data  <= rx_byte;                                          // R20 R23
							rd_valid <= 1'b1;                                             // R8 R19
							rd_left  <= rd_left - 9'h001;
							if (rd_left == `SFID_BYTE_ONE)
								state <= ST_END;                                          // R4
						end else if (rd_left != `SFID_BYTE_ZERO) begin
							// the byte just clocked was the opcode or the last header byte, so nothing is handed out yet
							rd_phase  <= 1'b1;
							tx_byte   <= 8'h00;
							serial_in <= 1'b0;
						end else begin
							state <= ST_END;                                              // R5 R3
						end
					end
				end
				ST_END: begin
					// frames always close on a byte boundary with clock low
					chip_select_n <= 1'b1;                                                 // R3 R5
					serial_clk    <= 1'b0;
					state         <= ST_GAP;
				end
				ST_GAP: begin
					if (wren_pending) begin
						wren_pending <= 1'b0;
						state        <= ST_SEL;
					end else begin
						done  <= 1'b1;
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
endmodule // sfid_host

/* File: tb/sfid_flash_model.sv */
// Purpose: behavioural flash device answering the sfid_host pins
// Assumes: mode 0 frames, host makes the serial clock
// Notes: busy lasts until a status poll ends; released output toggles so a stale bit never passes
module sfid_flash_model #(
	parameter logic [7:0]  maker_code_byte = 8'h3C, // arbitrary value
	parameter logic [7:0]  part_code_byte  = 8'h42, // arbitrary value
	parameter logic [15:0] part_code_word  = 16'h7A19 // arbitrary value
) (
	input  wire logic chip_select_n,
	input  wire logic serial_clk,
	input  wire logic serial_in,
	output logic      serial_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] sr;
	logic [23:0] adr;
	logic [7:0]  op = 8'hFF, st = 8'h00, ob;
	logic        write_permission_latch = 1'b0, busy = 1'b0;
	int          n = 0;
	initial serial_out = 1'b1;
	function automatic int hdr(logic [7:0] o);
		case (o)
			8'h05, 8'h9F: return 1;
			8'h03, 8'h53, 8'hAB, 8'h90: return 4;
			8'h0B, 8'h5B: return 5;
			default: return 0;
		endcase
	endfunction
	function automatic logic [7:0] rd_byte(int k);
		logic [23:0] a;
		a = (op[6] ? {16'h0, adr[7:0]} : adr) + 24'(k);
		case (op)
			8'h05: return {st[7:2], write_permission_latch, busy};
			8'h9F: return k == 0 ? maker_code_byte : k == 1 ? part_code_word[15:8] : part_code_word[7:0];
			8'h90: return k == 0 ? maker_code_byte : part_code_byte;
			8'hAB: return part_code_byte;
			default: return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'hA5;
		endcase
	endfunction
	always @(negedge chip_select_n) begin
		n = 0;
		op = 8'hFF;
	end
	always @(posedge serial_clk) if (!chip_select_n) begin
		sr = {sr[30:0], serial_in};
		n++;
		if (n == 8) op = sr[7:0];
		if (n == 32) adr = sr[23:0];
	end
	always @(negedge serial_clk) if (!chip_select_n) begin
		if (hdr(op) > 0 && n >= 8 * hdr(op) && (!busy || op == 8'h05)) begin
			ob = rd_byte(n / 8 - hdr(op));
			serial_out = ob[7 - n % 8];
		end else serial_out = ~serial_out;
	end
	// reads end on any bit; writes only on a byte with the latch set
	always @(posedge chip_select_n) begin
		serial_out = ~serial_out;
		if (busy) begin
			if (op == 8'h05) busy = 1'b0;
		end else begin
			if (n % 8 == 0 && write_permission_latch) case (op)
				8'h01: if (n == 16) begin
					st = {sr[7:2], 2'b00};
					write_permission_latch = 1'b0;
					busy = 1'b1;
				end
				8'h02, 8'h52, 8'hD8, 8'hC7, 8'hD5: begin
					write_permission_latch = 1'b0;
					busy = 1'b1;
				end
			endcase
			if (n == 8 && op == 8'h06) write_permission_latch = 1'b1;
			if (n == 8 && op == 8'h04) write_permission_latch = 1'b0;
		end
	end
endmodule // sfid_flash_model

/* File: tb/sfid_host_monitor.sv */
// Purpose: pin and handshake checks for sfid_host
// Assumes: half serial period of 4 core cycles
// Notes: bit count of a frame kept in helper logic
module sfid_host_monitor (
	input wire       core_clk, arst_n, cmd_valid, cmd_ready, done, cmd_error, rd_valid,
	input wire [7:0] cmd_opcode,
	input wire       chip_select_n, serial_clk, serial_in
);
	logic [2:0] bits;
	logic       clk_q;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			bits <= 3'h0;
			clk_q <= 1'b0;
		end else begin
			clk_q <= serial_clk;
			bits <= chip_select_n ? 3'h0 : bits + {2'h0, serial_clk & !clk_q};
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	chk_idle_cs_high: assert property (cmd_ready |-> chip_select_n) else $error("cs low while idle");
	chk_idle_clk_low: assert property (chip_select_n |-> !serial_clk) else $error("clock runs outside frame");
	chk_sel_follows: assert property (cmd_valid && cmd_ready && cmd_opcode != 8'h02 && cmd_opcode != 8'h52
		|-> ##[1:8] !chip_select_n) else $error("no frame after command");
	chk_high_phase: assert property ($rose(serial_clk) |-> serial_clk [*4] ##1 !serial_clk)
		else $error("bad high phase");
	chk_data_hold: assert property (serial_clk |-> $stable(serial_in)) else $error("data moved while clock high");
	chk_byte_end: assert property ($rose(chip_select_n) |-> bits == 3'h0) else $error("frame off byte");
	chk_err_done: assert property (cmd_error |-> done) else $error("error without done");
	chk_done_pulse: assert property (done |=> !done) else $error("done longer than a cycle");
	chk_take_busy: assert property (cmd_valid && cmd_ready |=> !cmd_ready) else $error("ready after take");
	cov_read: cover property (cmd_valid && cmd_ready && cmd_opcode == 8'h03);
	cov_refuse: cover property (cmd_error);
	cov_byte: cover property (rd_valid);
endmodule // sfid_host_monitor
bind sfid_host sfid_host_monitor chk_u (.core_clk(core_clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
	.cmd_ready(cmd_ready), .done(done), .cmd_error(cmd_error), .rd_valid(rd_valid), .cmd_opcode(cmd_opcode),
	.chip_select_n(chip_select_n), .serial_clk(serial_clk), .serial_in(serial_in));

/* File: tb/sfid_host_bench.sv */
// Purpose: self-checking bench for sfid_host against a flash model
// Assumes: inputs change 1 ns after the rising edge
// Notes: outputs read at the falling edge, so no edge race
module sfid_host_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0]  mk = 8'h3C; // arbitrary identity values
	localparam logic [7:0]  pc = 8'h42;
	localparam logic [15:0] pw = 16'h7A19;
	logic        core_clk = 0, arst_n = 0, cmd_valid = 0, cmd_auto_wren = 0, erred;
	logic [7:0]  cmd_opcode = 0, wr_data = 0, s, got[$], e[$];
	logic [23:0] cmd_addr = 0, a;
	logic [8:0]  cmd_wr_count = 0, cmd_rd_count = 0;
	logic [7:0]  rops[4] = '{8'h03, 8'h0B, 8'h53, 8'h5B};
	logic [7:0]  eops[3] = '{8'hD8, 8'hC7, 8'hD5};
	wire         cmd_ready, wr_take, rd_valid, done, cmd_error, chip_select_n, serial_clk, serial_in, serial_out;
	wire  [7:0]  rd_data;
	int          failures = 0, num_checks = 0, takes, n;
	always #20 core_clk = ~core_clk;
	sfid_host dut_u (.core_clk(core_clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
		.cmd_addr(cmd_addr), .cmd_wr_count(cmd_wr_count), .cmd_rd_count(cmd_rd_count),
		.cmd_auto_wren(cmd_auto_wren), .cmd_ready(cmd_ready), .wr_data(wr_data), .wr_take(wr_take),
		.rd_data(rd_data), .rd_valid(rd_valid), .done(done), .cmd_error(cmd_error),
		.chip_select_n(chip_select_n), .serial_clk(serial_clk), .serial_in(serial_in), .serial_out(serial_out));
	sfid_flash_model #(.maker_code_byte(mk), .part_code_byte(pc), .part_code_word(pw)) flash_u (
		.chip_select_n(chip_select_n), .serial_clk(serial_clk), .serial_in(serial_in), .serial_out(serial_out));
	always @(negedge core_clk) begin
		if (rd_valid === 1'b1) got.push_back(rd_data);
		if (wr_take === 1'b1) takes++;
	end
	task automatic check(string what, logic [8:0] seen, logic [8:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic run(logic [7:0] op, logic [23:0] ad, int rc, int wc, logic aw, logic [7:0] wd);
		@(posedge core_clk);
		#1;
		got = {};
		takes = 0;
		{cmd_opcode, cmd_addr, cmd_rd_count, cmd_wr_count, cmd_auto_wren, wr_data} = {op, ad, 9'(rc), 9'(wc), aw, wd};
		cmd_valid = 1;
		do @(negedge core_clk); while (cmd_ready !== 1'b1);
		@(posedge core_clk);
		#1 cmd_valid = 0;
		do @(negedge core_clk); while (done !== 1'b1);
		erred = cmd_error;
	endtask
	function automatic logic [7:0] exp_data(logic [23:0] base, int k);
		logic [23:0] p;
		p = base + 24'(k);
		return p[7:0] ^ p[15:8] ^ p[23:16] ^ 8'hA5;
	endfunction
	task automatic expect_bytes(logic [7:0] x[$]);
		check("byte count", 9'(got.size()), 9'(x.size()));
		foreach (x[k]) check("byte", {1'b0, got[k]}, {1'b0, x[k]});
	endtask
	// longest run is four program frames of up to 256 bytes, near 70k cycles
	initial begin
		#4000000;
		failures++;
		test_done();
	end
	initial begin
		void'($urandom(32'h74000591));
		repeat (6) @(posedge core_clk);
		#1 arst_n = 1;
		foreach (rops[i]) begin
			a = 24'($urandom);
			n = $urandom_range(4, 1);
			run(rops[i], a, n, 0, 0, '0);
			if (rops[i][6]) a = {16'h0, a[7:0]};
			e = {};
			for (int k = 0; k < n; k++) e.push_back(exp_data(a, k));
			expect_bytes(e);
		end
		// reset in mid frame: pins must release at once, then commands resume
		@(posedge core_clk);
		#1 {cmd_opcode, cmd_rd_count, cmd_valid} = {8'h03, 9'h004, 1'b1};
		do @(negedge core_clk); while (cmd_ready !== 1'b1);
		@(posedge core_clk);
		#1 cmd_valid = 0;
		repeat (20) @(posedge core_clk);
		#1 arst_n = 0;
		#1 check("cut cs", {8'h0, chip_select_n}, 9'h001);
		check("cut clk", {8'h0, serial_clk}, 9'h000);
		check("cut ready", {8'h0, cmd_ready}, 9'h000);
		repeat (6) @(posedge core_clk);
		#1 arst_n = 1;
		run(8'h9F, '0, 3, 0, 0, '0);
		expect_bytes('{mk, pw[15:8], pw[7:0]});
		run(8'h90, '0, 2, 0, 0, '0);
		expect_bytes('{mk, pc});
		run(8'hB9, '0, 0, 0, 0, '0);
		run(8'hAB, '0, 1, 0, 0, '0);
		expect_bytes('{pc});
		s = 8'($urandom);
		run(8'h01, '0, 0, 0, 1, s);
		run(8'h05, '0, 2, 0, 0, '0);
		expect_bytes('{{s[7:2], 2'b01}, {s[7:2], 2'b01}});
		run(8'h01, '0, 0, 0, 0, ~s);
		run(8'h06, '0, 0, 0, 0, '0);
		run(8'h05, '0, 1, 0, 0, '0);
		expect_bytes('{{s[7:2], 2'b10}});
		run(8'h04, '0, 0, 0, 0, '0);
		run(8'h05, '0, 1, 0, 0, '0);
		expect_bytes('{{s[7:2], 2'b00}});
		for (int i = 0; i < 4; i++) begin
			n = i % 2 ? 256 : $urandom_range(255, 1);
			run(i > 1 ? 8'h52 : 8'h02, 24'($urandom) & 24'hFFFFFE, 0, n, 1, 8'($urandom));
			check("taken", 9'(takes), 9'(n));
			check("error", {8'h0, erred}, 9'h0);
		end
		run(8'h02, 24'h000101, 0, 4, 1, '0);
		check("odd addr", {erred, 8'(takes)}, 9'h100);
		run(8'h02, '0, 0, 257, 1, '0);
		check("too long", {erred, 8'(takes)}, 9'h100);
		foreach (eops[i]) begin
			run(eops[i], 24'($urandom), 0, 0, 1, '0);
			check("erase", {8'h0, erred}, 9'h0);
		end
		run(8'h77, '0, 0, 0, 0, '0);
		check("unknown op", {erred, 8'(takes)}, 9'h000);
		run(8'h05, '0, 1, 0, 0, '0);
		expect_bytes('{{s[7:2], 2'b01}});
		test_done();
	end
endmodule // sfid_host_bench
